// *** verilog/loader_map.svh ***
// Purpose: constants of the configuration loader and its serial memory port
// Assumes: 200 MHz system clock, 100 kHz serial clock toward the memory
// Notes: times are in ns; cycle counts derive from them
`ifndef LOADER_MAP_SVH
`define LOADER_MAP_SVH
`define CLK_PERIOD_NS 5
// quarter of a 100 kHz serial clock period
`define SCL_QTR_NS 2500
`define SCL_QTR_CYC ((`SCL_QTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// least write cycle time of the memory
`define EE_WR_NS 5000000
`define EE_WR_CYC ((`EE_WR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// arbitration timeout, 255 serial clock cycles
`define ARB_SCL_CYCLES 8'hFF
`define OP_XFER_MAX 8'h7F
`define OP_COND_BASE 8'hB0
`define OP_COND_MASK 8'hF0
`define OP_PAUSE 8'hFE
`define OP_END 8'hFF
`define HDR_BYTES 4
// memory device address; arbitrary value
`define EE_DEV_ADDR 7'h50
`define COND_W 4
`endif

// *** verilog/loader_pkg.sv ***
// Purpose: types shared by the loader and its byte engine
// Assumes: nothing
// Notes: state encodings are left to the tools
package loader_pkg;
  typedef enum {SQ_IDLE, SQ_HDR, SQ_OP, SQ_AHI, SQ_ALO, SQ_DATA, SQ_CKSUM,
                SQ_SV_HDR, SQ_SV_GET, SQ_SV_PUT, SQ_SV_CK} seq_state_t;
  typedef enum {BS_IDLE, BS_WAIT, BS_START, BS_BIT, BS_STOP, BS_HOLD} bus_state_t;
endpackage : loader_pkg

// *** verilog/i2c_byte_engine.sv ***
// Purpose: one random read or one byte write to the serial memory per request
// Assumes: scl_s and sda_s are already synchronised; bus_free comes from the monitor
// Notes: open-drain drive, a high level is always a release
`include "loader_map.svh"
module i2c_byte_engine
  import loader_pkg::*;
#(
  parameter int QTR_CYC = `SCL_QTR_CYC,
  parameter int WR_WAIT_CYC = `EE_WR_CYC,
  parameter logic [6:0] DEV_ADDR = `EE_DEV_ADDR
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic req_wr,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_data,
  output logic done,
  output logic [7:0] rd_data,
  output logic waiting,
  input wire logic bus_free,
  input wire logic scl_s,
  input wire logic sda_s,
  output logic sda_lo,
  output logic scl_lo
);
  localparam int QW = $clog2(QTR_CYC + 1);
  localparam int WW = $clog2(WR_WAIT_CYC + 1);
  if (QTR_CYC < 2 || WR_WAIT_CYC < 1) begin : g_bad_param
    $error("engine timing parameters too small");
  end

  bus_state_t st_r;
  logic [1:0] ph_r;
  logic [QW-1:0] qc_r;
  logic [WW-1:0] wc_r;
  logic [3:0] bit_r;
  logic [2:0] byt_r;
  logic [7:0] sh_r;
  logic [7:0] rx_r;
  logic [7:0] rd_data_r;
  logic rst_r, retry_r, nack_r, done_r, sda_lo_r, scl_lo_r;
  logic qtick, reading, want_hi;
  logic [2:0] last_byte;

  function automatic logic [7:0] byte_at(input logic [2:0] idx);
    case (idx)
      3'h0: byte_at = {DEV_ADDR, 1'b0};
      3'h1: byte_at = req_addr[15:8];
      3'h2: byte_at = req_addr[7:0];
      3'h3: byte_at = req_wr ? req_data : {DEV_ADDR, 1'b1};
      default: byte_at = 8'hFF;
    endcase
  endfunction : byte_at

  assign qtick = (qc_r == QW'(QTR_CYC - 1));
  assign reading = !req_wr && (byt_r == 3'h4);
  assign last_byte = req_wr ? 3'h3 : 3'h4;
  assign want_hi = (bit_r < 4'h8) && !reading && sh_r[7];

  always_ff @(posedge clk) begin
    qc_r <= (!nrst || qtick) ? '0 : qc_r + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= BS_IDLE;
      ph_r <= 2'h0;
      wc_r <= '0;
      bit_r <= 4'h0;
      byt_r <= 3'h0;
      sh_r <= 8'hFF;
      rx_r <= 8'h00;
      rd_data_r <= 8'h00;
      rst_r <= 1'b0;
      retry_r <= 1'b0;
      nack_r <= 1'b0;
      done_r <= 1'b0;
      sda_lo_r <= 1'b0;
      scl_lo_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (st_r)
        BS_IDLE: begin
          // the request of a finished transfer may still stand for a cycle
          if (req && !done_r) st_r <= BS_WAIT;
        end
        BS_WAIT: begin
          sda_lo_r <= 1'b0;
          scl_lo_r <= 1'b0;
          if (bus_free && scl_s) begin
            st_r <= BS_START;
            ph_r <= 2'h0;
            rst_r <= 1'b0;
            byt_r <= 3'h0;
          end
        end
        BS_START: if (qtick) begin
          unique case (ph_r)
            2'h0: begin
              if (!rst_r && !scl_s) st_r <= BS_WAIT;
              else begin
                sda_lo_r <= 1'b0;
                ph_r <= 2'h1;
              end
            end
            2'h1: begin
              scl_lo_r <= 1'b0;
              ph_r <= 2'h2;
            end
            2'h2: if (scl_s) begin
              sda_lo_r <= 1'b1;
              ph_r <= 2'h3;
            end
            2'h3: begin
              scl_lo_r <= 1'b1;
              ph_r <= 2'h0;
              bit_r <= 4'h0;
              sh_r <= byte_at(byt_r);
              st_r <= BS_BIT;
            end
          endcase
        end
        BS_BIT: if (qtick) begin
          unique case (ph_r)
            2'h0: begin
              sda_lo_r <= (bit_r < 4'h8) && !reading && !sh_r[7];
              ph_r <= 2'h1;
            end
            2'h1: begin
              scl_lo_r <= 1'b0;
              ph_r <= 2'h2;
            end
            2'h2: if (scl_s) begin // waits out clock stretching
              if (want_hi && !sda_s) begin
                st_r <= BS_WAIT;
                sda_lo_r <= 1'b0;
              end else begin
                ph_r <= 2'h3;
                if (bit_r < 4'h8) rx_r <= {rx_r[6:0], sda_s};
                else nack_r <= sda_s;
              end
            end
            2'h3: begin
              scl_lo_r <= 1'b1;
              ph_r <= 2'h0;
              if (bit_r != 4'h8) begin
                bit_r <= bit_r + 4'h1;
                sh_r <= {sh_r[6:0], 1'b0};
              end else if (!reading && nack_r) begin
                // memory busy with an earlier write: release and retry
                st_r <= BS_STOP;
                retry_r <= 1'b1;
              end else if (byt_r == last_byte) begin
                st_r <= BS_STOP;
                retry_r <= 1'b0;
              end else if (!req_wr && byt_r == 3'h2) begin
                st_r <= BS_START;
                rst_r <= 1'b1;
                byt_r <= 3'h3;
              end else begin
                byt_r <= byt_r + 3'h1;
                bit_r <= 4'h0;
                sh_r <= byte_at(byt_r + 3'h1);
              end
            end
          endcase
        end
        BS_STOP: if (qtick) begin
          unique case (ph_r)
            2'h0: begin
              sda_lo_r <= 1'b1;
              ph_r <= 2'h1;
            end
            2'h1: begin
              scl_lo_r <= 1'b0;
              ph_r <= 2'h2;
            end
            2'h2: if (scl_s) begin
              sda_lo_r <= 1'b0;
              ph_r <= 2'h3;
            end
            2'h3: begin
              ph_r <= 2'h0;
              wc_r <= '0;
              if (retry_r) st_r <= BS_WAIT;
              else if (req_wr) st_r <= BS_HOLD;
              else begin
                rd_data_r <= rx_r;
                done_r <= 1'b1;
                st_r <= BS_IDLE;
              end
            end
          endcase
        end
        BS_HOLD: begin
          wc_r <= wc_r + 1'b1;
          if (wc_r == WW'(WR_WAIT_CYC - 1)) begin
            done_r <= 1'b1;
            st_r <= BS_IDLE;
          end
        end
      endcase
    end
  end

  assign done = done_r;
  assign rd_data = rd_data_r;
  assign waiting = (st_r == BS_WAIT);
  assign sda_lo = sda_lo_r;
  assign scl_lo = scl_lo_r;
endmodule : i2c_byte_engine

// *** verilog/eeprom_sequence_loader.sv ***
// Purpose: walk a stored instruction stream on load, write one out on save
// Assumes: control inputs come from logic on clk; bus pins are asynchronous
// Notes: every memory byte costs one full bus transaction; simple, not fast
`include "loader_map.svh"
// Notes on behaviour
// - nonzero condition value joins the condition map
// - condition zero empties map, execution unconditional
// - conditional and end instructions always execute
// - empty map or zero ID executes all
// - map holding the ID executes following instructions
// - otherwise skip until zero or matching condition
// - map holds several condition values at once
// - pause acts only in save, then idle
// - pause keeps the memory address pointer
// - save end writes end, checksum, clears pointer
// - load end clears pointer, checks checksum, idles
// - bus start and stop watched at all times
// - busy bus holds a pending transfer back
// - low data while sending high loses bus
// - low clock before start holds off driving
// - winner finishes; loser retries after stop
// - 255 clock cycles without stop forces attempt
// - timer restarts until transfer completes
// - condition value is code minus group base
// - condition ID is a four bit field
// - transfer code: address high first, code+1 bytes
// - header mismatch flags fault, abandons load
module eeprom_sequence_loader
  import loader_pkg::*;
#(
  parameter int QTR_CYC = `SCL_QTR_CYC,
  parameter int WR_WAIT_CYC = `EE_WR_CYC,
  parameter int HDR_N = `HDR_BYTES,
  parameter int COND_W = `COND_W,
  parameter logic [6:0] DEV_ADDR = `EE_DEV_ADDR
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load_start,
  input wire logic save_start,
  input wire logic [COND_W-1:0] cond_id,
  input wire logic [8*HDR_N-1:0] dev_ident,
  input wire logic [7:0] save_data,
  input wire logic save_valid,
  output logic save_ready,
  output logic reg_wr_valid,
  output logic [15:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  output logic action_valid,
  output logic [7:0] action_code,
  output logic busy,
  output logic seq_done,
  output logic header_fault,
  output logic checksum_fault,
  output logic [15:0] ee_ptr,
  output logic bus_busy,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n
);
  if (HDR_N < 1 || HDR_N > 255 || COND_W != 4) begin : g_bad_param
    $error("loader parameters out of range");
  end

  seq_state_t st_r;
  logic sda_m_r, sda_s_r, sda_p_r, scl_m_r, scl_s_r, scl_p_r;
  logic start_det, stop_det, scl_rise;
  logic busy_r;
  logic [7:0] arb_r;
  logic bus_free;
  logic ee_req, ee_wr, ee_done, eng_wait, sda_lo, scl_lo;
  logic [7:0] ee_rd, ee_wdata, io_byte, id_byte;
  logic [15:0] ptr_r;
  logic [7:0] ck_r;
  logic [7:0] hidx_r;
  logic [7:0] rem_r;
  logic [15:0] addr_r;
  logic exec_r, end_r;
  logic [7:0] sv_byte_r;
  logic [2**COND_W-1:0] map_r;
  logic exec_now, hdr_last, id_ok;
  logic op_cond, op_end, op_xfer;
  logic [COND_W-1:0] op_val;
  logic sv_take;

  // pin synchronisers; only the second stage and later are looked at
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {sda_m_r, sda_s_r, sda_p_r} <= 3'h7;
      {scl_m_r, scl_s_r, scl_p_r} <= 3'h7;
    end else begin
      {sda_m_r, sda_s_r, sda_p_r} <= {sda_in, sda_m_r, sda_s_r};
      {scl_m_r, scl_s_r, scl_p_r} <= {scl_in, scl_m_r, scl_s_r};
    end
  end

  assign start_det = scl_s_r && scl_p_r && sda_p_r && !sda_s_r;
  assign stop_det = scl_s_r && scl_p_r && !sda_p_r && sda_s_r;
  assign scl_rise = scl_s_r && !scl_p_r;

  always_ff @(posedge clk) begin
    if (!nrst) busy_r <= 1'b0;
    else if (start_det) busy_r <= 1'b1;
    else if (stop_det) busy_r <= 1'b0;
  end

  // arbitration timer runs only while a transfer is held back
  always_ff @(posedge clk) begin
    if (!nrst || !eng_wait) arb_r <= 8'h00;
    else if (scl_rise && arb_r != `ARB_SCL_CYCLES) arb_r <= arb_r + 8'h01;
  end

  assign bus_free = !busy_r || (arb_r == `ARB_SCL_CYCLES);

  i2c_byte_engine #(
    .QTR_CYC(QTR_CYC),
    .WR_WAIT_CYC(WR_WAIT_CYC),
    .DEV_ADDR(DEV_ADDR)
  ) u_engine (
    .clk(clk),
    .nrst(nrst),
    .req(ee_req),
    .req_wr(ee_wr),
    .req_addr(ptr_r),
    .req_data(ee_wdata),
    .done(ee_done),
    .rd_data(ee_rd),
    .waiting(eng_wait),
    .bus_free(bus_free),
    .scl_s(scl_s_r),
    .sda_s(sda_s_r),
    .sda_lo(sda_lo),
    .scl_lo(scl_lo)
  );

  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe_n = !sda_lo;
  assign scl_oe_n = !scl_lo;

  assign ee_req = st_r inside {SQ_HDR, SQ_OP, SQ_AHI, SQ_ALO, SQ_DATA, SQ_CKSUM,
                               SQ_SV_HDR, SQ_SV_PUT, SQ_SV_CK};
  assign ee_wr = st_r inside {SQ_SV_HDR, SQ_SV_PUT, SQ_SV_CK};
  assign id_byte = dev_ident[(HDR_N - 1 - int'(hidx_r)) * 8 +: 8];
  assign hdr_last = (hidx_r == 8'(HDR_N - 1));
  assign id_ok = (ee_rd == id_byte);

  always_comb begin
    unique case (st_r)
      SQ_SV_HDR: ee_wdata = id_byte;
      SQ_SV_CK: ee_wdata = ck_r;
      default: ee_wdata = sv_byte_r;
    endcase
  end

  assign io_byte = ee_wr ? ee_wdata : ee_rd;

  // instruction decode of the byte just read
  assign op_cond = (ee_rd & `OP_COND_MASK) == `OP_COND_BASE;
  assign op_val = COND_W'(ee_rd - `OP_COND_BASE);
  assign op_end = (ee_rd == `OP_END);
  assign op_xfer = (ee_rd <= `OP_XFER_MAX);
  assign exec_now = (map_r == '0) || (cond_id == '0) || map_r[cond_id];

  assign save_ready = (st_r == SQ_SV_GET);
  assign sv_take = save_ready && save_valid;

  always_ff @(posedge clk) begin
    if (!nrst) st_r <= SQ_IDLE;
    else begin
      unique case (st_r)
        SQ_IDLE: begin
          if (load_start) st_r <= SQ_HDR;
          else if (save_start) st_r <= (ptr_r == 16'h0000) ? SQ_SV_HDR : SQ_SV_GET;
        end
        SQ_HDR: if (ee_done) begin
          if (!id_ok) st_r <= SQ_IDLE;
          else if (hdr_last) st_r <= SQ_OP;
        end
        SQ_OP: if (ee_done) begin
          if (op_end) st_r <= SQ_CKSUM;
          else if (op_xfer) st_r <= SQ_AHI;
        end
        SQ_AHI: if (ee_done) st_r <= SQ_ALO;
        SQ_ALO: if (ee_done) st_r <= SQ_DATA;
        SQ_DATA: if (ee_done && rem_r == 8'h00) st_r <= SQ_OP;
        SQ_CKSUM: if (ee_done) st_r <= SQ_IDLE;
        SQ_SV_HDR: if (ee_done && hdr_last) st_r <= SQ_SV_GET;
        SQ_SV_GET: if (sv_take) begin
          if (rem_r == 8'h00 && save_data == `OP_PAUSE) st_r <= SQ_IDLE;
          else st_r <= SQ_SV_PUT;
        end
        SQ_SV_PUT: if (ee_done) st_r <= end_r ? SQ_SV_CK : SQ_SV_GET;
        SQ_SV_CK: if (ee_done) st_r <= SQ_IDLE;
      endcase
    end
  end

  // pointer and running checksum; a pause leaves both as they are
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ptr_r <= 16'h0000;
      ck_r <= 8'h00;
    end else if (st_r == SQ_IDLE) begin
      if (load_start) begin
        ptr_r <= 16'h0000;
        ck_r <= 8'h00;
      end else if (save_start && ptr_r == 16'h0000) begin
        ck_r <= 8'h00;
      end
    end else if (ee_done) begin
      if (st_r == SQ_CKSUM || st_r == SQ_SV_CK) ptr_r <= 16'h0000;
      else if (st_r == SQ_HDR && !id_ok) ptr_r <= 16'h0000;
      else begin
        ptr_r <= ptr_r + 16'h0001;
        ck_r <= ck_r + io_byte;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) hidx_r <= 8'h00;
    else if (st_r == SQ_IDLE) hidx_r <= 8'h00;
    else if (ee_done && (st_r == SQ_HDR || st_r == SQ_SV_HDR)) hidx_r <= hidx_r + 8'h01;
  end

  // condition map: one bit per nonzero condition value
  always_ff @(posedge clk) begin
    if (!nrst) map_r <= '0;
    else if (st_r == SQ_IDLE && load_start) map_r <= '0;
    else if (st_r == SQ_OP && ee_done && op_cond) begin
      if (op_val == '0) map_r <= '0;
      else map_r[op_val] <= 1'b1;
    end
  end

  // transfer bookkeeping, also used to pass payload through on save
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rem_r <= 8'h00;
      addr_r <= 16'h0000;
      exec_r <= 1'b0;
      end_r <= 1'b0;
      sv_byte_r <= 8'h00;
    end else begin
      if (st_r == SQ_IDLE && (load_start || save_start)) begin
        rem_r <= 8'h00;
        end_r <= 1'b0;
      end
      if (ee_done) begin
        unique case (st_r)
          SQ_OP: if (op_xfer) begin
            rem_r <= ee_rd;
            exec_r <= exec_now;
          end
          SQ_AHI: addr_r[15:8] <= ee_rd;
          SQ_ALO: addr_r[7:0] <= ee_rd;
          SQ_DATA: begin
            addr_r <= addr_r + 16'h0001;
            rem_r <= rem_r - 8'h01;
          end
          default: ;
        endcase
      end
      if (sv_take) begin
        sv_byte_r <= save_data;
        if (rem_r != 8'h00) rem_r <= rem_r - 8'h01;
        else if (save_data <= `OP_XFER_MAX) rem_r <= save_data + 8'h03;
        else if (save_data == `OP_END) end_r <= 1'b1;
      end
    end
  end

  // register writes and device actions toward the rest of the chip
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_wr_valid <= 1'b0;
      reg_wr_addr <= 16'h0000;
      reg_wr_data <= 8'h00;
      action_valid <= 1'b0;
      action_code <= 8'h00;
    end else begin
      reg_wr_valid <= 1'b0;
      action_valid <= 1'b0;
      if (st_r == SQ_DATA && ee_done && exec_r) begin
        reg_wr_valid <= 1'b1;
        reg_wr_addr <= addr_r;
        reg_wr_data <= ee_rd;
      end
      // a pause met while loading is read and stepped over
      if (st_r == SQ_OP && ee_done && exec_now && !op_cond && !op_end && !op_xfer
          && ee_rd != `OP_PAUSE) begin
        action_valid <= 1'b1;
        action_code <= ee_rd;
      end
    end
  end

  // status; faults stay until the next load is started
  always_ff @(posedge clk) begin
    if (!nrst) begin
      header_fault <= 1'b0;
      checksum_fault <= 1'b0;
      seq_done <= 1'b0;
    end else begin
      seq_done <= 1'b0;
      if (st_r == SQ_IDLE && load_start) begin
        header_fault <= 1'b0;
        checksum_fault <= 1'b0;
      end
      if (st_r == SQ_HDR && ee_done && !id_ok) begin
        header_fault <= 1'b1;
        seq_done <= 1'b1;
      end
      if (st_r == SQ_CKSUM && ee_done) begin
        checksum_fault <= (ee_rd != ck_r);
        seq_done <= 1'b1;
      end
      if (st_r == SQ_SV_CK && ee_done) seq_done <= 1'b1;
      if (sv_take && rem_r == 8'h00 && save_data == `OP_PAUSE) seq_done <= 1'b1;
    end
  end

  assign busy = (st_r != SQ_IDLE);
  assign ee_ptr = ptr_r;
  assign bus_busy = busy_r;
endmodule : eeprom_sequence_loader

// *** testbench/eeprom_model.sv ***
// Purpose: serial memory on the shared bus
// Assumes: both lines pulled up; 256 bytes mirrored
// Notes: no clock stretching; acks its own address only
module eeprom_model #(
  parameter logic [6:0] DEV = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [15:0] a;
  logic rd;
  int bc;
  int ph;
  initial begin
    sda_oe_n = 1'b1;
    ph = -1;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    bc = 0;
    ph = 0;
    rd = 1'b0;
    sda_oe_n = 1'b1;
  end
  always @(posedge sda) if (scl === 1'b1) ph = -1;
  always @(posedge scl) if (ph >= 0) begin
    if (bc < 8) begin
      sh = {sh[6:0], sda};
      bc++;
    end else if (rd && sda) ph = -1;
  end
  always @(negedge scl) if (ph >= 0) begin
    if (bc == 8) begin
      bc = 9;
      sda_oe_n = 1'b1;
      if (rd) a++;
      else if (ph > 0 || sh[7:1] == DEV) begin
        sda_oe_n = 1'b0;
        case (ph)
          0: rd = sh[0];
          1: a[15:8] = sh;
          2: a[7:0] = sh;
          default: begin
            mem[a[7:0]] = sh;
            a++;
          end
        endcase
        ph++;
      end
    end else begin
      if (bc == 9) bc = 0;
      sda_oe_n = rd ? mem[a[7:0]][7-bc] : 1'b1;
    end
  end
endmodule : eeprom_model

// *** testbench/eeprom_sequence_loader_chk.sv ***
// Purpose: port checks of the sequence loader
// Assumes: bound to each loader instance
// Notes: hold-off is only trusted below 254 foreign clocks
module eeprom_sequence_loader_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load_start,
  input wire logic save_start,
  input wire logic busy,
  input wire logic seq_done,
  input wire logic header_fault,
  input wire logic checksum_fault,
  input wire logic [15:0] ee_ptr,
  input wire logic reg_wr_valid,
  input wire logic bus_busy,
  input wire logic sda_in,
  input wire logic scl_in,
  input wire logic sda_oe_n,
  input wire logic scl_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic ld_r, own_r, scl_d_r;
  logic [8:0] rise_r;
  always_ff @(posedge clk) begin
    if (!nrst) ld_r <= 1'b0;
    else if (!busy && (load_start || save_start)) ld_r <= load_start;
  end
  // own traffic keeps the bus busy until our stop is seen
  always_ff @(posedge clk) begin
    if (!nrst) own_r <= 1'b0;
    else if (!sda_oe_n || !scl_oe_n) own_r <= 1'b1;
    else if (!bus_busy) own_r <= 1'b0;
  end
  always_ff @(posedge clk) begin
    scl_d_r <= scl_in;
    if (!nrst || !bus_busy) rise_r <= 9'h000;
    else if (scl_in && !scl_d_r && rise_r != 9'h1FF) rise_r <= rise_r + 9'h001;
  end
  a_done_ends_busy: assert property (seq_done |=> !busy)
    else $error("busy after sequence end");
  a_load_end_ptr: assert property (seq_done && ld_r |=> header_fault || ee_ptr == 16'h0000)
    else $error("pointer not cleared at load end");
  a_faults_cleared: assert property (load_start && !busy |=> !header_fault && !checksum_fault)
    else $error("faults kept over a new load");
  a_idle_ptr_kept: assert property (!busy && !$past(busy) |-> $stable(ee_ptr))
    else $error("pointer moved while idle");
  a_bus_start_seen: assert property ($fell(sda_in) && scl_in && $past(scl_in) |-> ##[1:5] bus_busy)
    else $error("start not tracked");
  a_bus_stop_seen: assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:5] !bus_busy)
    else $error("stop not tracked");
  a_busy_holds_off: assert property (bus_busy && !own_r && rise_r < 9'h0FE |-> sda_oe_n && scl_oe_n)
    else $error("drove a busy bus");
  a_start_scl_high: assert property ($fell(sda_oe_n) && scl_oe_n |-> scl_in)
    else $error("start with clock low");
  a_reg_wr_pulse: assert property (reg_wr_valid |-> busy ##1 !reg_wr_valid)
    else $error("register write outside a load");
  cover property (seq_done && ld_r);
  cover property (seq_done && !ld_r);
  cover property ($rose(checksum_fault));
  cover property (bus_busy && !own_r);
endmodule : eeprom_sequence_loader_chk

bind eeprom_sequence_loader eeprom_sequence_loader_chk chk (.clk, .nrst, .load_start,
  .save_start, .busy, .seq_done, .header_fault, .checksum_fault, .ee_ptr, .reg_wr_valid,
  .bus_busy, .sda_in, .scl_in, .sda_oe_n, .scl_oe_n);

// *** testbench/eeprom_sequence_loader_tb_top.sv ***
// Purpose: self-checking bench for the sequence loader
// Assumes: short bus quarter and write wait keep the run small
// Notes: the bench also acts as a second bus master
module eeprom_sequence_loader_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] bytes_t[$];
  // identity value is arbitrary
  localparam logic [31:0] IDENT = 32'h5A3C96E1;
  logic clk, nrst, load_start, save_start, save_valid, tb_sda, tb_scl, ee_oe_n, held;
  logic save_ready, reg_wr_valid, action_valid, busy, seq_done, header_fault;
  logic checksum_fault, bus_busy, sda_oe_n, scl_oe_n;
  logic [3:0] cond_id;
  logic [31:0] dev_ident;
  logic [7:0] save_data, reg_wr_data, action_code;
  logic [15:0] reg_wr_addr, ee_ptr;
  logic [24:0] ev_q[$], exp_q[$];
  wire logic sda_w, scl_w;
  int error_cnt, num_checks;
  assign sda_w = sda_oe_n & ee_oe_n & tb_sda;
  assign scl_w = scl_oe_n & tb_scl;
  eeprom_sequence_loader #(.QTR_CYC(4), .WR_WAIT_CYC(10)) uut (
    .clk, .nrst, .load_start, .save_start, .cond_id, .dev_ident, .save_data, .save_valid,
    .save_ready, .reg_wr_valid, .reg_wr_addr, .reg_wr_data, .action_valid, .action_code,
    .busy, .seq_done, .header_fault, .checksum_fault, .ee_ptr, .bus_busy, .sda_in(sda_w),
    .sda_out(), .sda_oe_n, .scl_in(scl_w), .scl_out(), .scl_oe_n);
  eeprom_model ee (.scl(scl_w), .sda(sda_w), .sda_oe_n(ee_oe_n));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (reg_wr_valid === 1'b1) ev_q.push_back({1'b0, reg_wr_addr, reg_wr_data});
    if (action_valid === 1'b1) ev_q.push_back({17'h10000, action_code});
  end
  task automatic chk(input string nm, input logic [24:0] got, input logic [24:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  function automatic bytes_t img(input bytes_t s);
    logic [7:0] c;
    bytes_t h;
    c = 8'h00;
    h = {IDENT[31:24], IDENT[23:16], IDENT[15:8], IDENT[7:0], s};
    foreach (h[i]) c += h[i];
    h.push_back(c);
    return h;
  endfunction : img
  task automatic go(input logic ld);
    @(negedge clk);
    load_start = ld;
    save_start = !ld;
    @(negedge clk);
    load_start = 1'b0;
    save_start = 1'b0;
    @(negedge clk);
  endtask : go
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    chk("idle", busy, 1'b0);
  endtask : idle
  task automatic sv(input logic [7:0] b);
    int n;
    n = 0;
    while (save_ready !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk("save_ready", save_ready, 1'b1);
    save_data = b;
    save_valid = 1'b1;
    @(negedge clk);
    save_valid = 1'b0;
  endtask : sv
  task automatic ld_cmp();
    ev_q.delete();
    go(1'b1);
    idle();
    chk("ee_ptr", ee_ptr, 16'h0000);
    chk("events", ev_q.size(), exp_q.size());
    foreach (exp_q[i]) chk("event", ev_q[i], exp_q[i]);
  endtask : ld_cmp
  // another master holds the bus with a start and a running clock
  task automatic t_arb();
    dev_ident = ~IDENT;
    held = 1'b0;
    #1.3;
    tb_sda = 1'b0;
    repeat (6) @(negedge clk);
    go(1'b1);
    repeat (40) begin
      #32;
      tb_scl = ~tb_scl;
      held = held | !(sda_oe_n & scl_oe_n);
    end
    chk("bus_busy", bus_busy, 1'b1);
    chk("held off", held, 1'b0);
    #32;
    tb_sda = 1'b1;
    idle();
    chk("header_fault", header_fault, 1'b1);
    chk("no events", ev_q.size(), 0);
    dev_ident = IDENT;
  endtask : t_arb
  task automatic t_cond();
    logic [3:0] ids[3];
    ids = '{4'h0, 4'h2, 4'h4};
    foreach (ids[i]) begin
      cond_id = ids[i];
      exp_q = '{25'h01234AA};
      if (ids[i] == 4'h0) exp_q = {exp_q, 25'h02000B1, 25'h02001B2};
      if (ids[i] != 4'h4) exp_q = {exp_q, 25'h03000C3, 25'h1000091};
      exp_q.push_back(25'h1000080);
      ld_cmp();
      chk("header_fault", header_fault, 1'b0);
      chk("checksum_fault", checksum_fault, 1'b0);
    end
  endtask : t_cond
  task automatic t_save();
    bytes_t e;
    e = img('{8'h00, 8'h40, 8'h00, 8'h5A, 8'hB1, 8'hFF});
    ee.mem[8] = 8'hEE;
    go(1'b0);
    for (int i = 4; i < 8; i++) sv(e[i]);
    sv(8'hFE);
    idle();
    chk("pause ptr", ee_ptr, 16'h0008);
    chk("pause byte", ee.mem[8], 8'hEE);
    go(1'b0);
    sv(8'hB1);
    sv(8'hFF);
    idle();
    chk("end ptr", ee_ptr, 16'h0000);
    foreach (e[i]) chk("stored", ee.mem[i], e[i]);
  endtask : t_save
  task automatic t_ck();
    ee.mem[10] = ee.mem[10] ^ 8'h01;
    cond_id = 4'h3;
    exp_q = '{25'h040005A};
    ld_cmp();
    chk("checksum_fault", checksum_fault, 1'b1);
  endtask : t_ck
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // the tests need about 80k cycles, some 400 us; a hang stops near 95k cycles
  initial begin
    #475000;
    error_cnt++;
    summarize();
  end
  initial begin
    bytes_t e;
    nrst = 1'b0;
    load_start = 1'b0;
    save_start = 1'b0;
    save_valid = 1'b0;
    save_data = 8'h00;
    cond_id = 4'h0;
    dev_ident = IDENT;
    tb_sda = 1'b1;
    tb_scl = 1'b1;
    error_cnt = 0;
    num_checks = 0;
    e = img('{8'h00, 8'h12, 8'h34, 8'hAA, 8'hB1, 8'h01, 8'h20, 8'h00, 8'hB1, 8'hB2, 8'hB2,
              8'hB3, 8'h00, 8'h30, 8'h00, 8'hC3, 8'h91, 8'hB0, 8'h80, 8'hFE, 8'hFF});
    foreach (e[i]) ee.mem[i] = e[i];
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    t_arb();
    t_cond();
    t_save();
    t_ck();
    summarize();
  end
endmodule : eeprom_sequence_loader_tb_top
